// file: core/imdl_top.sv
// dump/load internal memory command engine with its register slave
//
// Notes on behaviour
// - opcode 20 octal copies the internal memory span into the host buffer.
// - opcode 21 octal copies host buffer words into internal memory.
// - word count comes from bits 15:1 of parameter word 0.
// - host buffer address is word 2 bits 15:1 plus word 4 bits 1:0.
// - internal address is word 6 bits 15:1 plus word 10 low byte.
// - dump may read 0 to 1FFFE and 80000 to 83FFE.
// - in halted state load may write 4400 to 1FFFE.
// - in ready state load may write only 4400 to 6400.
`timescale 1ns/1ps
`default_nettype none
module imdl_top
  import imdl_pkg::*;
#(
  parameter int COUNT_W = 15
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write channels
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // host memory dma port
  output logic hmem_req,
  output logic hmem_we,
  output logic [17:0] hmem_addr,
  output logic [15:0] hmem_wdata,
  input wire logic [15:0] hmem_rdata,
  input wire logic hmem_ack,
  // internal memory port
  output logic imem_req,
  output logic imem_we,
  output logic [23:0] imem_addr,
  output logic [15:0] imem_wdata,
  input wire logic [15:0] imem_rdata,
  input wire logic imem_ack,
  // activity
  output logic busy
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FETCH = 3'b001,
    ST_CHECK = 3'b010,
    ST_SRC = 3'b011,
    ST_DST = 3'b100
  } imdl_state_type;

  typedef struct packed {
    imdl_state_type state;
    logic [3:0] idx;
    logic [FETCH_WORDS-1:0][15:0] words;
    logic halted;
    logic is_load;
    logic hreq;
    logic hwe;
    logic [17:0] haddr;
    logic [15:0] hwdata;
    logic ireq;
    logic iwe;
    logic [23:0] iaddr;
    logic [15:0] iwdata;
    logic [COUNT_W-1:0] remaining;
    logic [COUNT_W-1:0] moved;
    logic busy;
    logic done;
    logic error;
    imdl_err_type err_code;
    logic [7:0] opcode;
  } imdl_engine_type;

  imdl_engine_type r;
  imdl_engine_type next_r;
  imdl_reg_if rif ();

  imdl_axi_regs imdl_axi_regs_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .eng(rif.regs)
  );

  // fields decoded from the fetched words
  logic [17:0] par_base;
  logic [COUNT_W-1:0] word_count;
  logic [17:0] host_buffer_base;
  logic [23:0] internal_buffer_base;
  logic [24:0] span_last;
  logic span_ok;

  // only bits 1:0 of command word 4 count; its high byte is never looked at
  assign par_base = {r.words[IX_CMD_HI][1:0], r.words[IX_CMD_LO][15:1], 1'b0};
  assign word_count = r.words[IX_COUNT][15:1];
  assign host_buffer_base = {r.words[IX_HOST_HI][1:0], r.words[IX_HOST_LO][15:1], 1'b0};
  assign internal_buffer_base = {r.words[IX_INT_HI][7:0], r.words[IX_INT_LO][15:1], 1'b0};
  // last word touched; a span that runs past the top of the address space fails
  assign span_last = {1'b0, internal_buffer_base} + {9'h000, word_count - 15'h0001, 1'b0};

  always_comb
  begin
    span_ok = 1'b0;
    if (span_last[24])
      span_ok = 1'b0;
    // decoded from the fetched opcode, since is_load is only registered after this check
    else if (r.words[IX_OPCODE][7:0] != OP_LOAD)
      span_ok = (internal_buffer_base >= DUMP_LO1 && span_last[23:0] <= DUMP_HI1) ||
        (internal_buffer_base >= DUMP_LO2 && span_last[23:0] <= DUMP_HI2);
    else if (r.halted)
      span_ok = internal_buffer_base >= LOAD_LO && span_last[23:0] <= LOAD_HALTED_HI;
    else
      span_ok = internal_buffer_base >= LOAD_LO && span_last[23:0] <= LOAD_READY_HI;
  end

  assign hmem_req = r.hreq;
  assign hmem_we = r.hwe;
  assign hmem_addr = r.haddr;
  assign hmem_wdata = r.hwdata;
  assign imem_req = r.ireq;
  assign imem_we = r.iwe;
  assign imem_addr = r.iaddr;
  assign imem_wdata = r.iwdata;
  assign busy = r.busy;
  assign rif.busy = r.busy;
  assign rif.done = r.done;
  assign rif.error = r.error;
  assign rif.err_code = r.err_code;
  assign rif.opcode = r.opcode;
  assign rif.moved = r.moved;

  always_comb
  begin
    next_r = r;
    // software clears first so that a completion in the same cycle wins
    if (rif.clr_done)
      next_r.done = 1'b0;
    if (rif.clr_err)
      next_r.error = 1'b0;
    case (r.state)
      ST_IDLE:
      begin
        // a start while busy is never seen here and is dropped
        if (rif.start)
        begin
          next_r.state = ST_FETCH;
          next_r.idx = 4'h0;
          next_r.halted = rif.halted;
          next_r.busy = 1'b1;
          next_r.done = 1'b0;
          next_r.error = 1'b0;
          next_r.err_code = ERR_NONE;
          next_r.moved = '0;
        end
      end
      ST_FETCH:
      begin
        if (!r.hreq)
        begin
          next_r.hreq = 1'b1;
          next_r.hwe = 1'b0;
          if (r.idx < 4'(CMD_WORDS))
            next_r.haddr = 18'(rif.cmd_base + {13'h0000, r.idx, 1'b0});
          else
            next_r.haddr = 18'(par_base + PAR_OFF[3'(r.idx - 4'(CMD_WORDS))]);
        end
        else if (hmem_ack)
        begin
          next_r.hreq = 1'b0;
          next_r.words[3'(r.idx)] = hmem_rdata;
          next_r.idx = r.idx + 4'h1;
          if (r.idx == 4'(FETCH_WORDS - 1))
            next_r.state = ST_CHECK;
        end
      end
      ST_CHECK:
      begin
        next_r.opcode = r.words[IX_OPCODE][7:0];
        next_r.is_load = r.words[IX_OPCODE][7:0] == OP_LOAD;
        next_r.remaining = word_count;
        next_r.haddr = host_buffer_base;
        next_r.iaddr = internal_buffer_base;
        if (r.words[IX_OPCODE][7:0] != OP_DUMP && r.words[IX_OPCODE][7:0] != OP_LOAD)
        begin
          next_r.state = ST_IDLE;
          next_r.busy = 1'b0;
          next_r.error = 1'b1;
          next_r.err_code = ERR_OPCODE;
        end
        else if (word_count == '0)
        begin
          next_r.state = ST_IDLE;
          next_r.busy = 1'b0;
          next_r.done = 1'b1;
        end
        else if (!span_ok)
        begin
          next_r.state = ST_IDLE;
          next_r.busy = 1'b0;
          next_r.error = 1'b1;
          next_r.err_code = ERR_RANGE;
        end
        else
        begin
          next_r.state = ST_SRC;
          if (r.words[IX_OPCODE][7:0] == OP_DUMP)
          begin
            next_r.ireq = 1'b1;
            next_r.iwe = 1'b0;
          end
          else
          begin
            next_r.hreq = 1'b1;
            next_r.hwe = 1'b0;
          end
        end
      end
      ST_SRC:
      begin
        if (!r.is_load && imem_ack)
        begin
          // dump: internal word goes out to the host buffer
          next_r.ireq = 1'b0;
          next_r.hreq = 1'b1;
          next_r.hwe = 1'b1;
          next_r.hwdata = imem_rdata;
          next_r.state = ST_DST;
        end
        else if (r.is_load && hmem_ack)
        begin
          next_r.hreq = 1'b0;
          next_r.ireq = 1'b1;
          next_r.iwe = 1'b1;
          next_r.iwdata = hmem_rdata;
          next_r.state = ST_DST;
        end
      end
      ST_DST:
      begin
        if ((!r.is_load && hmem_ack) || (r.is_load && imem_ack))
        begin
          next_r.hreq = 1'b0;
          next_r.ireq = 1'b0;
          next_r.hwe = 1'b0;
          next_r.iwe = 1'b0;
          next_r.haddr = r.haddr + WORD_STEP;
          next_r.iaddr = r.iaddr + INT_STEP;
          next_r.remaining = r.remaining - 15'h0001;
          next_r.moved = r.moved + 15'h0001;
          if (r.remaining == 15'h0001)
          begin
            next_r.state = ST_IDLE;
            next_r.busy = 1'b0;
            next_r.done = 1'b1;
          end
          else
          begin
            next_r.state = ST_SRC;
            next_r.ireq = !r.is_load;
            next_r.hreq = r.is_load;
          end
        end
      end
      default:
      begin
        next_r.state = ST_IDLE;
        next_r.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      r <= '0;
    else
      r <= next_r;
  end
endmodule
`default_nettype wire

// file: core/imdl_pkg.sv
// constants and types shared by the internal memory dump/load command block
package imdl_pkg;
  // register byte addresses on the control bus
  localparam logic [31:0] REG_CTRL = 32'h0000_0000;
  localparam logic [31:0] REG_CMD_BASE = 32'h0000_0004;
  localparam logic [31:0] REG_STATUS = 32'h0000_0008;
  localparam logic [31:0] REG_MOVED = 32'h0000_000C;
  localparam int REG_SEL_LSB = 2;

  // control register fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_HALTED_BIT = 1;
  localparam logic CTRL_HALTED_RESET = 1'b1;

  // status register fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_ERR_BIT = 2;
  localparam int STAT_CODE_LSB = 4;
  localparam int STAT_OP_LSB = 8;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [17:0] CMD_BASE_RESET = 18'h00000;

  // function codes (printed in octal as 20 and 21)
  localparam logic [7:0] OP_DUMP = 8'h10;
  localparam logic [7:0] OP_LOAD = 8'h11;

  // host memory layout of command block and parameter block
  localparam int FETCH_WORDS = 8;
  localparam int CMD_WORDS = 3;
  localparam logic [17:0] WORD_STEP = 18'h00002;
  localparam logic [23:0] INT_STEP = 24'h000002;
  // parameter block offsets 0,2,4,6 and 10 octal (byte 8)
  localparam logic [4:0][17:0] PAR_OFF = {18'h00008, 18'h00006, 18'h00004, 18'h00002, 18'h00000};
  localparam int IX_OPCODE = 0;
  localparam int IX_CMD_LO = 1;
  localparam int IX_CMD_HI = 2;
  localparam int IX_COUNT = 3;
  localparam int IX_HOST_LO = 4;
  localparam int IX_HOST_HI = 5;
  localparam int IX_INT_LO = 6;
  localparam int IX_INT_HI = 7;

  // internal address windows
  localparam logic [23:0] DUMP_LO1 = 24'h000000;
  localparam logic [23:0] DUMP_HI1 = 24'h01FFFE;
  localparam logic [23:0] DUMP_LO2 = 24'h080000;
  localparam logic [23:0] DUMP_HI2 = 24'h083FFE;
  localparam logic [23:0] LOAD_LO = 24'h004400;
  localparam logic [23:0] LOAD_HALTED_HI = 24'h01FFFE;
  localparam logic [23:0] LOAD_READY_HI = 24'h006400;

  typedef enum logic [1:0] {
    ERR_NONE = 2'b00,
    ERR_OPCODE = 2'b01,
    ERR_RANGE = 2'b10
  } imdl_err_type;
endpackage

// file: core/imdl_reg_if.sv
// link between the register slave and the command engine
`timescale 1ns/1ps
`default_nettype none
interface imdl_reg_if;
  import imdl_pkg::*;
  logic start;
  logic halted;
  logic [17:0] cmd_base;
  logic clr_done;
  logic clr_err;
  logic busy;
  logic done;
  logic error;
  imdl_err_type err_code;
  logic [7:0] opcode;
  logic [14:0] moved;
  modport regs (output start, output halted, output cmd_base, output clr_done, output clr_err,
    input busy, input done, input error, input err_code, input opcode, input moved);
  modport engine (input start, input halted, input cmd_base, input clr_done, input clr_err,
    output busy, output done, output error, output err_code, output opcode, output moved);
endinterface
`default_nettype wire

// file: core/imdl_axi_regs.sv
// axi4-lite register slave of the dump/load command block
`timescale 1ns/1ps
`default_nettype none
module imdl_axi_regs
  import imdl_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address and data
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read address and data
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // engine side
  imdl_reg_if.regs eng
);
  typedef struct packed {
    logic aw_got;
    logic [31:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic start;
    logic halted;
    logic [17:0] cmd_base;
    logic clr_done;
    logic clr_err;
  } imdl_slave_type;

  imdl_slave_type r;
  imdl_slave_type next_r;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val, input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        m[i*8 +: 8] = val[i*8 +: 8];
    end
    return m;
  endfunction

  assign s_axi_awready = !r.aw_got && !r.bvalid;
  assign s_axi_wready = !r.w_got && !r.bvalid;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign eng.start = r.start;
  assign eng.halted = r.halted;
  assign eng.cmd_base = r.cmd_base;
  assign eng.clr_done = r.clr_done;
  assign eng.clr_err = r.clr_err;

  always_comb
  begin
    logic [31:0] m;
    m = 32'h0000_0000;
    next_r = r;
    next_r.start = 1'b0;
    next_r.clr_done = 1'b0;
    next_r.clr_err = 1'b0;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_r.aw_got = 1'b1;
      next_r.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_r.w_got = 1'b1;
      next_r.wdata = s_axi_wdata;
      next_r.wstrb = s_axi_wstrb;
    end
    if (r.aw_got && r.w_got)
    begin
      next_r.aw_got = 1'b0;
      next_r.w_got = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = RESP_OKAY;
      m = merge(32'h0000_0000, r.wdata, r.wstrb);
      if (r.awaddr[31:REG_SEL_LSB] == REG_CTRL[31:REG_SEL_LSB])
      begin
        m = merge({30'h0, r.halted, 1'b0}, r.wdata, r.wstrb);
        next_r.start = m[CTRL_START_BIT];
        next_r.halted = m[CTRL_HALTED_BIT];
      end
      else if (r.awaddr[31:REG_SEL_LSB] == REG_CMD_BASE[31:REG_SEL_LSB])
      begin
        m = merge({14'h0, r.cmd_base}, r.wdata, r.wstrb);
        // command block is word aligned, low bit held at zero
        next_r.cmd_base = {m[17:1], 1'b0};
      end
      else if (r.awaddr[31:REG_SEL_LSB] == REG_STATUS[31:REG_SEL_LSB])
      begin
        next_r.clr_done = m[STAT_DONE_BIT];
        next_r.clr_err = m[STAT_ERR_BIT];
      end
      else if (r.awaddr[31:REG_SEL_LSB] != REG_MOVED[31:REG_SEL_LSB])
        next_r.bresp = RESP_SLVERR;
    end
    if (r.bvalid && s_axi_bready)
      next_r.bvalid = 1'b0;
    if (r.rvalid && s_axi_rready)
      next_r.rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_r.rvalid = 1'b1;
      next_r.rresp = RESP_OKAY;
      next_r.rdata = 32'h0000_0000;
      if (s_axi_araddr[31:REG_SEL_LSB] == REG_CTRL[31:REG_SEL_LSB])
        next_r.rdata[CTRL_HALTED_BIT] = r.halted;
      else if (s_axi_araddr[31:REG_SEL_LSB] == REG_CMD_BASE[31:REG_SEL_LSB])
        next_r.rdata[17:0] = r.cmd_base;
      else if (s_axi_araddr[31:REG_SEL_LSB] == REG_STATUS[31:REG_SEL_LSB])
      begin
        next_r.rdata[STAT_BUSY_BIT] = eng.busy;
        next_r.rdata[STAT_DONE_BIT] = eng.done;
        next_r.rdata[STAT_ERR_BIT] = eng.error;
        next_r.rdata[STAT_CODE_LSB +: 2] = eng.err_code;
        next_r.rdata[STAT_OP_LSB +: 8] = eng.opcode;
      end
      else if (s_axi_araddr[31:REG_SEL_LSB] == REG_MOVED[31:REG_SEL_LSB])
        next_r.rdata[14:0] = eng.moved;
      else
        next_r.rresp = RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r <= '0;
      r.halted <= CTRL_HALTED_RESET;
      r.cmd_base <= CMD_BASE_RESET;
    end
    else
      r <= next_r;
  end
endmodule
`default_nettype wire

// file: testbench/imdl_checker.sv
// port-level assertions for the dump/load command block
`timescale 1ns/1ps
`default_nettype none
module imdl_checker
  import imdl_pkg::*;
#(
  parameter int COUNT_W = 15
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus answers
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // memory ports
  input wire logic hmem_req,
  input wire logic hmem_we,
  input wire logic [17:0] hmem_addr,
  input wire logic [15:0] hmem_wdata,
  input wire logic [15:0] hmem_rdata,
  input wire logic hmem_ack,
  input wire logic imem_req,
  input wire logic imem_we,
  input wire logic [23:0] imem_addr,
  input wire logic [15:0] imem_wdata,
  input wire logic [15:0] imem_rdata,
  input wire logic imem_ack,
  input wire logic busy
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic hrd;
  logic ird;
  assign hrd = hmem_req && hmem_ack && !hmem_we;
  assign ird = imem_req && imem_ack && !imem_we;
  host_hold_a: assert property (hmem_req && !hmem_ack |=> hmem_req && $stable(hmem_addr) && $stable(hmem_we))
    else $error("host request moved before ack");
  int_hold_a: assert property (imem_req && !imem_ack |=> imem_req && $stable(imem_addr) && $stable(imem_wdata))
    else $error("internal request moved before ack");
  dump_window_a: assert property (imem_req && !imem_we |-> imem_addr <= DUMP_HI1 ||
    (imem_addr >= DUMP_LO2 && imem_addr <= DUMP_HI2)) else $error("dump read outside window");
  load_window_a: assert property (imem_req && imem_we |-> imem_addr >= LOAD_LO && imem_addr <= LOAD_HALTED_HI)
    else $error("load write outside window");
  dump_pair_a: assert property (ird |=> hmem_req && hmem_we && hmem_wdata == $past(imem_rdata))
    else $error("dumped word not passed to host");
  load_pair_a: assert property (hrd ##1 imem_req |-> imem_we && imem_wdata == $past(hmem_rdata))
    else $error("loaded word not passed inward");
  idle_quiet_a: assert property (!busy |-> !hmem_req && !imem_req)
    else $error("memory request while idle");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  cover property (ird ##1 hmem_req);
  cover property (hrd ##1 imem_req);
  cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule
bind imdl_top imdl_checker #(.COUNT_W(COUNT_W)) imdl_checker_inst (.aclk(aclk), .aresetn(aresetn),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .hmem_req(hmem_req), .hmem_we(hmem_we),
  .hmem_addr(hmem_addr), .hmem_wdata(hmem_wdata), .hmem_rdata(hmem_rdata), .hmem_ack(hmem_ack),
  .imem_req(imem_req), .imem_we(imem_we), .imem_addr(imem_addr), .imem_wdata(imem_wdata),
  .imem_rdata(imem_rdata), .imem_ack(imem_ack), .busy(busy));
`default_nettype wire

// file: testbench/imdl_mem_model.sv
// word memory answering the block's requests with a chosen wait
`timescale 1ns/1ps
`default_nettype none
module imdl_mem_model
#(
  parameter int AW = 18
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // request
  input wire logic req,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [3:0] wait_n,
  // answer
  output logic [15:0] rdata,
  output logic ack
);
  logic [15:0] mem [logic [AW-1:0]];
  int cnt;
  int n_wr;
  // read data flips outside the ack cycle so a stale word never matches
  always @(posedge aclk)
  begin
    rdata <= ~rdata;
    ack <= 1'b0;
    if (!aresetn)
    begin
      cnt <= 0;
      rdata <= 16'h0F0F;
    end
    else if (req && !ack && cnt >= int'(wait_n))
    begin
      ack <= 1'b1;
      cnt <= 0;
      if (we)
      begin
        mem[addr] = wdata;
        n_wr <= n_wr + 1;
      end
      else
        rdata <= mem.exists(addr) ? mem[addr] : 16'hDEAD;
    end
    else
      cnt <= (req && !ack) ? cnt + 1 : 0;
  end
endmodule
`default_nettype wire

// file: testbench/internal_memory_dump_load_cmd_tb_top.sv
// self-checking bench for the dump/load command block
`timescale 1ns/1ps
`default_nettype none
module internal_memory_dump_load_cmd_tb_top;
  import imdl_pkg::*;
  localparam logic [17:0] CB = 18'h00100;
  localparam logic [17:0] PB = 18'h10200;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0] wstrb, hwait, iwait;
  logic [1:0] bresp, rresp;
  logic hreq, hwe, hack, ireq, iwe, iack, busy;
  logic [17:0] haddr;
  logic [23:0] iaddr;
  logic [15:0] hwd, hrd, iwd, ird;
  int n_fail = 0;
  int cmp_count = 0;
  imdl_top #(.COUNT_W(15)) imdl_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .hmem_req(hreq), .hmem_we(hwe), .hmem_addr(haddr), .hmem_wdata(hwd), .hmem_rdata(hrd), .hmem_ack(hack),
    .imem_req(ireq), .imem_we(iwe), .imem_addr(iaddr), .imem_wdata(iwd), .imem_rdata(ird), .imem_ack(iack),
    .busy(busy));
  imdl_mem_model #(.AW(18)) host_mem_inst (.aclk(aclk), .aresetn(aresetn), .req(hreq), .we(hwe),
    .addr(haddr), .wdata(hwd), .wait_n(hwait), .rdata(hrd), .ack(hack));
  imdl_mem_model #(.AW(24)) int_mem_inst (.aclk(aclk), .aresetn(aresetn), .req(ireq), .we(iwe),
    .addr(iaddr), .wdata(iwd), .wait_n(iwait), .rdata(ird), .ack(iack));
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic final_report;
  begin
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
  begin
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  // bready and rready stay high throughout, which the bus allows
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_left;
    logic w_left;
  begin
    aw_left = 1'b1;
    w_left = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    // answers are looked at mid-cycle so the edge that changes them is never raced
    while (aw_left || w_left)
    begin
      @(negedge aclk);
      if (awready)
        aw_left = 1'b0;
      if (wready)
        w_left = 1'b0;
      @(posedge aclk);
      if (!aw_left)
        awvalid <= 1'b0;
      if (!w_left)
        wvalid <= 1'b0;
    end
    do
      @(negedge aclk);
    while (!bvalid);
    r = bresp;
    @(posedge aclk);
  end
  endtask
  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
  begin
    araddr <= a;
    arvalid <= 1'b1;
    do
      @(negedge aclk);
    while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do
      @(negedge aclk);
    while (!rvalid);
    d = rdata;
    r = rresp;
    @(posedge aclk);
  end
  endtask
  function automatic logic [15:0] ipat(input logic [23:0] a);
    return a[15:0] ^ 16'h5A5A;
  endfunction
  function automatic logic [15:0] hpat(input logic [17:0] a);
    return a[15:0] ^ 16'hC3C3;
  endfunction
  task automatic run(input logic [7:0] op, input logic [14:0] n, input logic [17:0] h, input logic [23:0] ia,
    input logic hl, input logic [1:0] code);
    logic [31:0] d;
    logic [1:0] r;
    int hw;
    int iw;
  begin
    host_mem_inst.mem[CB] = {8'h00, op};
    host_mem_inst.mem[CB + 18'h2] = {PB[15:1], 1'b0};
    // ignored high byte of word 4 and all of word 6 carry junk
    host_mem_inst.mem[CB + 18'h4] = {8'hA5, 6'h00, PB[17:16]};
    host_mem_inst.mem[CB + 18'h6] = 16'hFFFF;
    host_mem_inst.mem[PB] = {n, 1'b0};
    host_mem_inst.mem[PB + 18'h2] = {h[15:1], 1'b0};
    host_mem_inst.mem[PB + 18'h4] = {14'h0, h[17:16]};
    host_mem_inst.mem[PB + 18'h6] = {ia[15:1], 1'b0};
    host_mem_inst.mem[PB + 18'h8] = {8'h00, ia[23:16]};
    for (int k = 0; k < n; k++)
    begin
      host_mem_inst.mem[h + 18'(2 * k)] = hpat(h + 18'(2 * k));
      int_mem_inst.mem[ia + 24'(2 * k)] = ipat(ia + 24'(2 * k));
    end
    hw = host_mem_inst.n_wr;
    iw = int_mem_inst.n_wr;
    axi_wr(REG_CMD_BASE, {14'h0, CB}, r);
    axi_wr(REG_CTRL, {30'h0, hl, 1'b0}, r);
    axi_wr(REG_CTRL, {30'h0, hl, 1'b1}, r);
    @(negedge aclk);
    for (int t = 0; t < 4000 && busy !== 1'b0; t++)
      @(negedge aclk);
    check({31'h0, busy}, 32'h0);
    @(posedge aclk);
    axi_rd(REG_STATUS, d, r);
    if (code == ERR_NONE)
    begin
      check(d, {16'h0, op, 2'h0, code, 4'h2});
      axi_rd(REG_MOVED, d, r);
      check(d, {17'h0, n});
      for (int k = 0; k < n; k++)
        if (op == OP_DUMP)
          check(32'(host_mem_inst.mem[h + 18'(2 * k)]), 32'(ipat(ia + 24'(2 * k))));
        else
          check(32'(int_mem_inst.mem[ia + 24'(2 * k)]), 32'(hpat(h + 18'(2 * k))));
    end
    else
    begin
      check(d, {16'h0, op, 2'h0, code, 4'h4});
      check(32'(host_mem_inst.n_wr - hw + int_mem_inst.n_wr - iw), 32'h0);
    end
    axi_wr(REG_STATUS, 32'h0000_0006, r);
  end
  endtask
  initial
  begin
    #400000;
    n_fail++;
    final_report();
  end
  initial
  begin : main
    logic [31:0] d;
    logic [1:0] r;
    aresetn = 1'b0;
    {awvalid, wvalid, arvalid} = 3'h0;
    {bready, rready} = 2'h3;
    {awaddr, wdata, araddr} = 96'h0;
    wstrb = 4'hF;
    hwait = 4'h2;
    iwait = 4'h1;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(REG_CTRL, d, r);
    check(d, 32'h0000_0002);
    axi_rd(REG_CMD_BASE, d, r);
    check(d, 32'h0);
    axi_rd(32'h0000_0010, d, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    axi_wr(32'h0000_0010, 32'h1, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    run(OP_DUMP, 15'd3, 18'h20010, 24'h083FFA, 1'b1, ERR_NONE);
    run(OP_LOAD, 15'd2, 18'h30000, 24'h0063FE, 1'b0, ERR_NONE);
    hwait <= 4'h0;
    iwait <= 4'h0;
    run(OP_DUMP, 15'd2, 18'h00400, 24'h01FFFC, 1'b0, ERR_NONE);
    run(OP_DUMP, 15'd2, 18'h00400, 24'h01FFFE, 1'b1, ERR_RANGE);
    run(OP_DUMP, 15'd1, 18'h00400, 24'h07FFFE, 1'b1, ERR_RANGE);
    run(OP_LOAD, 15'd1, 18'h30000, 24'h006402, 1'b0, ERR_RANGE);
    run(OP_LOAD, 15'd1, 18'h30000, 24'h0043FE, 1'b1, ERR_RANGE);
    run(OP_LOAD, 15'd2, 18'h30000, 24'h01FFFC, 1'b1, ERR_NONE);
    run(8'h12, 15'd1, 18'h00400, 24'h000000, 1'b1, ERR_OPCODE);
    final_report();
  end
endmodule
`default_nettype wire
